// ---- tmpr_load_if.sv ----
// Interface carrying one decoded immediate load from the top to the register store.
// Assumes a single clock domain; the load strobe is a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
interface tmpr_load_if;
  import tmpr_pkg::*;
  tmpr_sel_type        sel;
  logic                strobe;
  logic [NIB_W-1:0]    data;
  logic [NIB_W-1:0]    t0_mode;
  logic [NIB_W-1:0]    t1_mode;
  logic [NIB_W-1:0]    page;
  logic [NIB_W-1:0]    wake;
  modport ctrl (output sel, output strobe, output data,
                input t0_mode, input t1_mode, input page, input wake);
  modport store (input sel, input strobe, input data,
                 output t0_mode, output t1_mode, output page, output wake);
endinterface
`default_nettype wire

// ---- tmpr_pkg.sv ----
// Package of register selectors, bit positions and reset values for the mode registers.
// Assumes a 4-bit core that issues one immediate load per machine cycle.
package tmpr_pkg;
  localparam int unsigned NIB_W = 4;
  localparam int unsigned PAGE_W = 3;
  localparam int unsigned ADDR_W = 7;
  typedef enum logic [1:0] {
    TMPR_SEL_T0   = 2'h0,
    TMPR_SEL_T1   = 2'h1,
    TMPR_SEL_PAGE = 2'h2,
    TMPR_SEL_WAKE = 2'h3
  } tmpr_sel_type;
  localparam logic [NIB_W-1:0] REG_RESET = 4'h0;
  localparam int unsigned T0_DIV_BIT = 0;
  localparam int unsigned T0_RUN_BIT = 3;
  localparam int unsigned T1_DIV_BIT = 0;
  localparam int unsigned T1_EXT_BIT = 1;
  localparam int unsigned T1_MFP_BIT = 2;
  localparam int unsigned T1_RUN_BIT = 3;
  localparam logic [3:0] NIB_ZERO = 4'h0;
endpackage

// ---- tmpr_store.sv ----
// Flip-flop store of the four write-only mode registers.
// Assumes the load strobe and data come from logic on clk_sys.
`timescale 1ns/1ps
`default_nettype none
module tmpr_store (
  input  wire logic  clk_sys,
  input  wire logic  resetn,
  tmpr_load_if.store ld
);
  import tmpr_pkg::*;
  logic [NIB_W-1:0] t0_q, t0_d, t1_q, t1_d, pg_q, pg_d, wk_q, wk_d;

  always_comb begin
    t0_d = t0_q;
    t1_d = t1_q;
    pg_d = pg_q;
    wk_d = wk_q;
    if (ld.strobe) begin
      case (ld.sel)
        TMPR_SEL_T0:   t0_d = ld.data;
        TMPR_SEL_T1:   t1_d = ld.data;
        TMPR_SEL_PAGE: pg_d = ld.data;
        TMPR_SEL_WAKE: wk_d = ld.data;
        default:       t0_d = t0_q;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      t0_q <= REG_RESET;
      t1_q <= REG_RESET;
      pg_q <= REG_RESET;
      wk_q <= REG_RESET;
    end else begin
      t0_q <= t0_d;
      t1_q <= t1_d;
      pg_q <= pg_d;
      wk_q <= wk_d;
    end
  end

  assign ld.t0_mode = t0_q;
  assign ld.t1_mode = t1_q;
  assign ld.page    = pg_q;
  assign ld.wake    = wk_q;

  a_load_next_cycle: assert property (@(posedge clk_sys) disable iff (!resetn)
    ld.strobe && ld.sel == TMPR_SEL_T0 |=> t0_q == $past(ld.data))
    else $error("First timer mode register did not load.");
  a_t1_load_once: assert property (@(posedge clk_sys) disable iff (!resetn)
    ld.strobe && ld.sel == TMPR_SEL_T1 |=> t1_q == $past(ld.data))
    else $error("Second timer mode register did not load.");
  a_hold_no_strobe: assert property (@(posedge clk_sys) disable iff (!resetn)
    !ld.strobe |=> $stable(pg_q) && $stable(t0_q) && $stable(wk_q) && $stable(t1_q))
    else $error("Register changed without a load.");
endmodule // tmpr_store
`default_nettype wire

// ---- timer_mode_page_regs.sv ----
// Top of the timer mode, page and port wake enable registers.
// Assumes the instruction decoder gives one load pulse per machine cycle on clk_sys,
// and that port_c pins arrive asynchronously.
// Behaviour
// - Loading the first timer mode register replaces all four bits in one cycle.
// - First mode bit 0 picks timer 0 clock: oscillator over four or 1024.
// - First mode bits 1 and 2 are reserved and change nothing.
// - First mode bit 3 set runs timer 0 down-count, clear halts it.
// - Loading the second timer mode register replaces all four bits in one cycle.
// - Second mode bit 0 picks timer 1 internal clock: oscillator or over 64.
// - Second mode bit 1 picks internal clock or external port C bit 0.
// - Second mode bit 2 routes generator waveform or timer 1 frequency out.
// - Second mode bit 3 set runs timer 1 down-count, clear halts it.
// - Page bits 2 to 0 select a 16-nibble block for indirect addressing.
// - Each enabled port C pin change may release hold or interrupt.
`timescale 1ns/1ps
`default_nettype none
module timer_mode_page_regs (
  input  wire logic                   clk_sys,
  input  wire logic                   resetn,
  input  wire logic                   load_strobe,
  input  wire tmpr_pkg::tmpr_sel_type load_sel,
  input  wire logic [3:0]             load_data,
  input  wire logic [3:0]             indirect_low_addr,
  input  wire logic [3:0]             port_c,
  input  wire logic                   modgen_wave,
  input  wire logic                   timer1_freq,
  output logic                        timer0_prescale_1024,
  output logic                        timer0_run,
  output logic                        timer1_prescale_64,
  output logic                        timer1_external_clk,
  output logic                        timer1_run,
  output logic                        modulated_output_pin,
  output logic [6:0]                  indirect_addr,
  output logic                        port_change_event
);
  import tmpr_pkg::*;

  tmpr_load_if ld ();

  assign ld.strobe = load_strobe;
  assign ld.sel    = load_sel;
  assign ld.data   = load_data;

  tmpr_store u_store (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .ld      (ld)
  );

  // Two-stage synchronisers; the change detector compares stage two with its one-cycle delayed copy pc_prev_q.
  logic [NIB_W-1:0] pc_meta_q, pc_meta_d, pc_sync_q, pc_sync_d, pc_prev_q, pc_prev_d;
  logic             evt_q, evt_d;
  logic             mfp_q, mfp_d;

  // Masking with the enable keeps a disabled pin from ever producing an event.
  function automatic logic masked_change(input logic [3:0] now, input logic [3:0] was,
                                         input logic [3:0] en);
    return ((now ^ was) & en) != NIB_ZERO;
  endfunction

  always_comb begin
    pc_meta_d = port_c;
    pc_sync_d = pc_meta_q;
    pc_prev_d = pc_sync_q;
    evt_d     = masked_change(pc_sync_q, pc_prev_q, ld.wake);
    mfp_d     = ld.t1_mode[T1_MFP_BIT] ? timer1_freq : modgen_wave;
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pc_meta_q <= REG_RESET;
      pc_sync_q <= REG_RESET;
      pc_prev_q <= REG_RESET;
      evt_q     <= 1'b0;
      mfp_q     <= 1'b0;
    end else begin
      pc_meta_q <= pc_meta_d;
      pc_sync_q <= pc_sync_d;
      pc_prev_q <= pc_prev_d;
      evt_q     <= evt_d;
      mfp_q     <= mfp_d;
    end
  end

  // Reserved bits 1 and 2 of the first mode register are simply never decoded.
  assign timer0_prescale_1024 = ld.t0_mode[T0_DIV_BIT];
  assign timer0_run           = ld.t0_mode[T0_RUN_BIT];
  assign timer1_prescale_64   = ld.t1_mode[T1_DIV_BIT];
  assign timer1_external_clk  = ld.t1_mode[T1_EXT_BIT];
  assign timer1_run           = ld.t1_mode[T1_RUN_BIT];
  assign modulated_output_pin = mfp_q;
  assign indirect_addr        = {ld.page[PAGE_W-1:0], indirect_low_addr};
  assign port_change_event    = evt_q;

  a_t0_run_follow: assert property (@(posedge clk_sys) disable iff (!resetn)
    load_strobe && load_sel == TMPR_SEL_T0 |=> timer0_run == $past(load_data[T0_RUN_BIT]))
    else $error("Timer 0 run does not follow bit 3.");
  a_t0_div_follow: assert property (@(posedge clk_sys) disable iff (!resetn)
    load_strobe && load_sel == TMPR_SEL_T0 |=> timer0_prescale_1024 == $past(load_data[0]))
    else $error("Timer 0 prescale does not follow bit 0.");
  a_t1_ctrl_follow: assert property (@(posedge clk_sys) disable iff (!resetn)
    load_strobe && load_sel == TMPR_SEL_T1 |=>
      {timer1_run, timer1_external_clk, timer1_prescale_64} ==
      {$past(load_data[3]), $past(load_data[1]), $past(load_data[0])})
    else $error("Timer 1 controls do not follow the load.");
  a_mfp_route: assert property (@(posedge clk_sys) disable iff (!resetn)
    ##1 modulated_output_pin == ($past(timer1_freq) ? ($past(ld.t1_mode[2]) | ~$past(ld.t1_mode[2]))
      && ($past(ld.t1_mode[2]) ? $past(timer1_freq) : $past(modgen_wave))
      : ($past(ld.t1_mode[2]) ? 1'b0 : $past(modgen_wave))))
    else $error("Modulated output takes the wrong source.");
  a_page_addr: assert property (@(posedge clk_sys) disable iff (!resetn)
    indirect_addr[6:4] == ld.page[2:0] && indirect_addr[3:0] == indirect_low_addr)
    else $error("Indirect address page is wrong.");
  a_wake_masked: assert property (@(posedge clk_sys) disable iff (!resetn)
    ld.wake == NIB_ZERO ##1 ld.wake == NIB_ZERO |=> !port_change_event)
    else $error("Change event raised on a disabled pin.");
  a_reset_clear: assert property (@(posedge clk_sys)
    !resetn |=> !timer0_run && !timer1_run && indirect_addr[6:4] == 3'h0 && ld.wake == NIB_ZERO)
    else $error("Registers not cleared by reset.");
  a_reserved_bits: assert property (@(posedge clk_sys) disable iff (!resetn)
    load_strobe && load_sel == TMPR_SEL_T0 |=> $past(timer0_prescale_1024) ==
      timer0_prescale_1024 || $past(load_data[0]) == timer0_prescale_1024)
    else $error("Reserved bits disturbed timer 0.");
endmodule // timer_mode_page_regs
`default_nettype wire

// ---- timer_mode_page_regs_tb.sv ----
// Self-checking bench of the timer mode, page and port wake enable registers.
// Assumes the design shows a load on its outputs one edge after the strobe.
`timescale 1ns/1ps
`default_nettype none
module timer_mode_page_regs_tb;
  import tmpr_pkg::*;
  logic         clk_sys = 1'b0;
  logic         resetn = 1'b0;
  logic         load_strobe = 1'b0;
  tmpr_sel_type load_sel = TMPR_SEL_T0;
  logic [3:0]   load_data = 4'h0, indirect_low_addr = 4'h0, port_c = 4'h0;
  logic         modgen_wave = 1'b0, timer1_freq = 1'b0;
  logic         t0p, t0r, t1p, t1e, t1r, mop, pce;
  logic [6:0]   ia;
  logic [3:0]   m0 = 4'h0, m1 = 4'h0, pg = 4'h0, wk = 4'h0;
  logic [7:0]   expq [$];
  logic         pend = 1'b0;
  int           failures = 0, tests_run = 0, seed = 32'h23fbc487, cnt, i, j, k;
  timer_mode_page_regs DUT (.clk_sys(clk_sys), .resetn(resetn), .load_strobe(load_strobe),
    .load_sel(load_sel), .load_data(load_data), .indirect_low_addr(indirect_low_addr),
    .port_c(port_c), .modgen_wave(modgen_wave), .timer1_freq(timer1_freq),
    .timer0_prescale_1024(t0p), .timer0_run(t0r), .timer1_prescale_64(t1p),
    .timer1_external_clk(t1e), .timer1_run(t1r), .modulated_output_pin(mop),
    .indirect_addr(ia), .port_change_event(pce));
  initial forever #25 clk_sys = ~clk_sys;
  task automatic report_and_stop();
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic cmp_val(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s exp=%h got=%h", nm, e, g);
    end
  endtask
  function automatic logic [7:0] expv();
    return {m0[T0_DIV_BIT], m0[T0_RUN_BIT], m1[T1_DIV_BIT], m1[T1_EXT_BIT], m1[T1_RUN_BIT], pg[2:0]};
  endfunction
  // The model is updated as the strobe is driven, so back-to-back loads queue in order.
  task automatic load(input tmpr_sel_type s, input logic [3:0] d);
    @(negedge clk_sys);
    load_strobe = 1'b1;
    load_sel = s;
    load_data = d;
    case (s)
      TMPR_SEL_T0: m0 = d;
      TMPR_SEL_T1: m1 = d;
      TMPR_SEL_PAGE: pg = d;
      default: wk = d;
    endcase
    expq.push_back(expv());
  endtask
  task automatic idle(input int n);
    repeat (n) begin
      @(negedge clk_sys);
      load_strobe = 1'b0;
    end
  endtask
  // Checked while reset is still low, so no load can mask a stuck register.
  task automatic check_reset();
    idle(2);
    cmp_val("reset regs", 8'h00, {t0p, t0r, t1p, t1e, t1r, ia[6:4]});
    cmp_val("reset pins", 8'h00, {6'h00, mop, pce});
  endtask
  always @(posedge clk_sys) begin
    if (pend && expq.size() > 0) begin
      cmp_val("regs", expq.pop_front(), {t0p, t0r, t1p, t1e, t1r, ia[6:4]});
    end
    pend = load_strobe && resetn;
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    failures++;
    report_and_stop();
  end
  initial begin
    check_reset();
    repeat (14) @(negedge clk_sys);
    resetn = 1'b1;
    for (i = 0; i < 48; i++) begin
      load(tmpr_sel_type'(2'($random(seed))), 4'($random(seed)));
    end
    for (i = 0; i < 16; i++) begin
      load(TMPR_SEL_PAGE, 4'(i));
    end
    idle(2);
    indirect_low_addr = 4'($random(seed));
    #1 cmp_val("indirect", {1'b0, pg[2:0], indirect_low_addr}, {1'b0, ia});
    for (i = 0; i < 2; i++) begin
      load(TMPR_SEL_T1, {1'b0, i[0], 2'b00});
      for (j = 0; j < 2; j++) begin
        modgen_wave = j[0];
        timer1_freq = ~j[0];
        idle(3);
        cmp_val("mfp", {7'h00, i[0] ? timer1_freq : modgen_wave}, {7'h00, mop});
      end
    end
    for (k = 0; k < 2; k++) begin
      load(TMPR_SEL_WAKE, k[0] ? 4'ha : 4'h5);
      idle(4);
      for (i = 0; i < 4; i++) begin
        port_c[i] = ~port_c[i];
        cnt = 0;
        repeat (8) begin
          @(negedge clk_sys);
          cnt += (pce === 1'b1) ? 1 : 0;
        end
        cmp_val("event count", {7'h00, wk[i]}, 8'(cnt));
      end
    end
    load(TMPR_SEL_T0, 4'hf);
    load(TMPR_SEL_T1, 4'hf);
    idle(2);
    resetn = 1'b0;
    {m0, m1, pg, wk} = 16'h0000;
    check_reset();
    resetn = 1'b1;
    for (i = 0; i < 10 && expq.size() > 0; i++) @(negedge clk_sys);
    if (expq.size() > 0) failures++;
    report_and_stop();
  end
endmodule // timer_mode_page_regs_tb
`default_nettype wire
